// File: src/cms_pkg.sv
// Shared constants for the clock monitor status register block
package cms_pkg;
    // Bus decode
    localparam int ADDR_W = 8;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    // Register byte offsets
    localparam logic [7:0] CRYSTAL_LOSS_STATUS_OFS = 8'h00;
    localparam logic [7:0] CRYSTAL_OFFSET_STATUS_OFS = 8'h04;
    localparam logic [7:0] OUTPUT_FREQ_CHECK_STATUS_OFS = 8'h08;
    localparam logic [7:0] CRYSTAL_DISABLE_CTRL_OFS = 8'h0C;
    localparam logic [7:0] EVENT_STATUS_OFS = 8'h10;
    localparam logic [7:0] EVENT_MASK_OFS = 8'h14;
    // Sizes
    localparam int NUM_CRYSTALS = 2;
    localparam int NUM_OUTPUTS = 12;
    localparam int OFFSET_W = 8;
    localparam int EVT_W = 4;
    // Field positions
    localparam int LOS_LSB = 0;
    localparam int INVALID_LSB = 2;
    localparam int LOSS_RSVD_LSB = 4;
    localparam int OFFSET_LSB = 0;
    localparam int OUT_TRUE_LSB = 0;
    localparam int OUT_INV_LSB = 12;
    localparam int FREQ_RSVD_LSB = 24;
    localparam int EVT_XTAL0_INVALID = 0;
    localparam int EVT_XTAL1_INVALID = 1;
    localparam int EVT_OFFSET_REFRESH = 2;
    localparam int EVT_OUTPUT_FAIL = 3;
    // Reset values
    localparam logic [1:0] LOS_RESET = 2'h0;
    localparam logic [1:0] INVALID_RESET = 2'h0;
    localparam logic [7:0] OFFSET_RESET = 8'h00;
    localparam logic [11:0] OUT_FAIL_RESET = 12'h000;
    localparam logic [1:0] DISABLE_RESET = 2'h0;
    localparam logic [3:0] EVT_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;
    // Crystal clock cycles between offset refreshes
    localparam int XTAL_REFRESH_CYCLES = 500000;
endpackage

// File: src/cms_offset_sampler.sv
// Crystal offset sampler refreshed on a fixed count of crystal cycles
`timescale 1ns/1ps
`default_nettype none
module cms_offset_sampler #(
    parameter int REFRESH_CYCLES = cms_pkg::XTAL_REFRESH_CYCLES,
    parameter int OFFSET_W = cms_pkg::OFFSET_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Crystal monitor side
    input wire logic xtalTick,
    input wire logic [OFFSET_W-1:0] ppmMeasure,
    // Captured reading
    output logic [OFFSET_W-1:0] ppmValue_q,
    output logic refresh_q
);
    localparam int CNT_W = $clog2(REFRESH_CYCLES);
    localparam logic [CNT_W-1:0] LAST_COUNT = CNT_W'(REFRESH_CYCLES - 1);

    logic [CNT_W-1:0] tickCount_q;
    logic wrap;

    assign wrap = xtalTick && (tickCount_q == LAST_COUNT);

    // Counts crystal clock cycles
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tickCount_q <= '0;
        end else if (wrap) begin
            tickCount_q <= '0;
        end else if (xtalTick) begin
            tickCount_q <= tickCount_q + CNT_W'(1);
        end
    end

    // Captures the raw offset once per interval
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ppmValue_q <= cms_pkg::OFFSET_RESET;
            refresh_q <= 1'b0;
        end else begin
            refresh_q <= wrap;
            if (wrap) begin
                ppmValue_q <= ppmMeasure;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence lastTick_s;
        xtalTick && (tickCount_q == LAST_COUNT);
    endsequence

    refresh_capture_a: assert property (
        lastTick_s |=> refresh_q && (ppmValue_q == $past(ppmMeasure)))
        else $error("Offset not captured at end of interval");

    refresh_hold_a: assert property (
        !wrap |=> !refresh_q && $stable(ppmValue_q))
        else $error("Offset changed outside a refresh");
endmodule // cms_offset_sampler
`default_nettype wire

// File: src/cms_status_regs.sv
// Clock monitor status registers behind an AHB-Lite slave
//
// What this block does
// - A crystal reads invalid while its loss or stability monitor rejects it.
// - A crystal also reads invalid while software disables it.
// - Crystal invalid flags sit at bits 3:2, crystal one above crystal zero.
// - Live loss-of-signal flags sit at bits 1:0, crystal one above zero.
// - The offset register shows the raw 2 ppm per step reading in 7:0.
// - The offset reading refreshes once per 500000 crystal clock cycles.
// - Bits 23:12 hold the inverted output verdicts of the last window.
// - Bits 11:0 hold the true output verdicts of the last window.
// - Bit n of each twelve-bit field belongs to output clock n.
`timescale 1ns/1ps
`default_nettype none
module cms_status_regs #(
    parameter int REFRESH_CYCLES = cms_pkg::XTAL_REFRESH_CYCLES,
    parameter int NUM_OUT = cms_pkg::NUM_OUTPUTS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Crystal monitors
    input wire logic [1:0] losDetect,
    input wire logic [1:0] stabilityFail,
    input wire logic xtalTick,
    input wire logic [7:0] ppmMeasure,
    // Output frequency monitors
    input wire logic windowDone,
    input wire logic [NUM_OUT-1:0] trueOutFail,
    input wire logic [NUM_OUT-1:0] invertedOutFail,
    // Interrupt
    output logic irq
);
    localparam int AW = cms_pkg::ADDR_W;

    logic [1:0] los_q;
    logic [1:0] invalid_q;
    logic [1:0] xtalDisable_q;
    logic [NUM_OUT-1:0] trueFail_q;
    logic [NUM_OUT-1:0] invFail_q;
    logic [7:0] ppmValue;
    logic ppmRefresh;
    logic [3:0] evt_q;
    logic [3:0] evt_d;
    logic [3:0] evtSet;
    logic [3:0] evtClr;
    logic [3:0] mask_q;
    logic [31:0] rdata_q;
    logic wrPend_q;
    logic [AW-1:0] wrAddr_q;
    logic addrPhase;
    logic rdAccept;
    logic wrAccept;
    logic [AW-1:0] addrLow;
    logic [NUM_OUT-1:0] newTrueFail;
    logic [NUM_OUT-1:0] newInvFail;

    // Offset refresh counter and capture
    cms_offset_sampler #(
        .REFRESH_CYCLES(REFRESH_CYCLES),
        .OFFSET_W(cms_pkg::OFFSET_W)
    ) offsetSampler (
        .clock(clock),
        .reset_n(reset_n),
        .xtalTick(xtalTick),
        .ppmMeasure(ppmMeasure),
        .ppmValue_q(ppmValue),
        .refresh_q(ppmRefresh)
    );

    // Matches an address against a register offset
    function automatic logic hitReg(input logic [AW-1:0] a,
                                    input logic [7:0] ofs);
        hitReg = (a == AW'(ofs));
    endfunction

    // Assembles the read word for an offset
    function automatic logic [31:0] readWord(input logic [AW-1:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (hitReg(a, cms_pkg::CRYSTAL_LOSS_STATUS_OFS)) begin
            w[cms_pkg::LOS_LSB +: 2] = los_q;
            w[cms_pkg::INVALID_LSB +: 2] = invalid_q;
        end else if (hitReg(a, cms_pkg::CRYSTAL_OFFSET_STATUS_OFS)) begin
            w[cms_pkg::OFFSET_LSB +: 8] = ppmValue;
        end else if (hitReg(a, cms_pkg::OUTPUT_FREQ_CHECK_STATUS_OFS)) begin
            w[cms_pkg::OUT_TRUE_LSB +: NUM_OUT] = trueFail_q;
            w[cms_pkg::OUT_INV_LSB +: NUM_OUT] = invFail_q;
        end else if (hitReg(a, cms_pkg::CRYSTAL_DISABLE_CTRL_OFS)) begin
            w[1:0] = xtalDisable_q;
        end else if (hitReg(a, cms_pkg::EVENT_STATUS_OFS)) begin
            w[3:0] = evt_q;
        end else if (hitReg(a, cms_pkg::EVENT_MASK_OFS)) begin
            w[3:0] = mask_q;
        end
        readWord = w;
    endfunction

    // Bus handshake: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    assign addrLow = haddr[AW-1:0];
    assign addrPhase = hsel && hready &&
        (htrans == cms_pkg::HTRANS_NONSEQ || htrans == cms_pkg::HTRANS_SEQ);
    assign rdAccept = addrPhase && !hwrite;
    assign wrAccept = addrPhase && hwrite;

    // Read data captured at the end of the address phase
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (rdAccept) begin
            rdata_q <= readWord(addrLow);
        end
    end

    // Write address held into the data phase
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= '0;
        end else if (hready) begin
            wrPend_q <= wrAccept;
            wrAddr_q <= addrLow;
        end
    end

    // Software control registers; status offsets take no write
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            xtalDisable_q <= cms_pkg::DISABLE_RESET;
            mask_q <= cms_pkg::MASK_RESET;
        end else if (wrPend_q) begin
            if (hitReg(wrAddr_q, cms_pkg::CRYSTAL_DISABLE_CTRL_OFS)) begin
                xtalDisable_q <= hwdata[1:0];
            end
            if (hitReg(wrAddr_q, cms_pkg::EVENT_MASK_OFS)) begin
                mask_q <= hwdata[3:0];
            end
        end
    end

    // Crystal loss and invalid flags
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            los_q <= cms_pkg::LOS_RESET;
            invalid_q <= cms_pkg::INVALID_RESET;
        end else begin
            los_q <= losDetect;
            invalid_q <= losDetect | stabilityFail | xtalDisable_q;
        end
    end

    // Output verdicts latched at the close of each window
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            trueFail_q <= NUM_OUT'(cms_pkg::OUT_FAIL_RESET);
            invFail_q <= NUM_OUT'(cms_pkg::OUT_FAIL_RESET);
        end else if (windowDone) begin
            trueFail_q <= trueOutFail;
            invFail_q <= invertedOutFail;
        end
    end

    // Event sources
    assign newTrueFail = trueOutFail & ~trueFail_q;
    assign newInvFail = invertedOutFail & ~invFail_q;
    always_comb begin
        evtSet = 4'h0;
        evtSet[cms_pkg::EVT_XTAL0_INVALID] =
            (losDetect[0] | stabilityFail[0] | xtalDisable_q[0]) &
            ~invalid_q[0];
        evtSet[cms_pkg::EVT_XTAL1_INVALID] =
            (losDetect[1] | stabilityFail[1] | xtalDisable_q[1]) &
            ~invalid_q[1];
        evtSet[cms_pkg::EVT_OFFSET_REFRESH] = ppmRefresh;
        evtSet[cms_pkg::EVT_OUTPUT_FAIL] =
            windowDone && ((|newTrueFail) || (|newInvFail));
    end

    // Event status clears on read, a new event wins
    always_comb begin
        evtClr = 4'h0;
        if (rdAccept && hitReg(addrLow, cms_pkg::EVENT_STATUS_OFS)) begin
            evtClr = 4'hF;
        end
        evt_d = (evt_q & ~evtClr) | evtSet;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            evt_q <= cms_pkg::EVT_RESET;
        end else begin
            evt_q <= evt_d;
        end
    end

    assign irq = |(evt_q & mask_q);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence readOf_s(logic [7:0] ofs);
        rdAccept && hitReg(addrLow, ofs);
    endsequence

    sequence writeOf_s(logic [7:0] ofs);
        wrAccept && hitReg(addrLow, ofs);
    endsequence

    monitor_invalid_a: assert property (
        (losDetect[0] || stabilityFail[0]) |=> invalid_q[0])
        else $error("Crystal zero not flagged invalid");

    disable_invalid_a: assert property (
        xtalDisable_q[1] |=> invalid_q[1])
        else $error("Disabled crystal one not flagged invalid");

    valid_clears_a: assert property (
        !(losDetect[1] || stabilityFail[1] || xtalDisable_q[1])
        |=> !invalid_q[1])
        else $error("Crystal one invalid without cause");

    loss_layout_a: assert property (
        readOf_s(cms_pkg::CRYSTAL_LOSS_STATUS_OFS)
        |=> hrdata[3:2] == $past(invalid_q) &&
            hrdata[1:0] == $past(losDetect, 2) && hrdata[31:4] == 28'h0)
        else $error("Crystal loss word wrong");

    offset_read_a: assert property (
        readOf_s(cms_pkg::CRYSTAL_OFFSET_STATUS_OFS)
        |=> hrdata == {24'h0, $past(ppmValue)})
        else $error("Offset word wrong");

    window_latch_a: assert property (
        windowDone ##1 readOf_s(cms_pkg::OUTPUT_FREQ_CHECK_STATUS_OFS)
        |=> hrdata[23:12] == $past(invertedOutFail, 2) &&
            hrdata[11:0] == $past(trueOutFail, 2) &&
            hrdata[31:24] == 8'h0)
        else $error("Output verdict word wrong");

    window_hold_a: assert property (
        !windowDone |=> $stable(trueFail_q) && $stable(invFail_q))
        else $error("Output verdicts changed mid window");

    status_write_a: assert property (
        writeOf_s(cms_pkg::CRYSTAL_LOSS_STATUS_OFS) ##1 !windowDone
        |=> $stable(invFail_q) && $stable(xtalDisable_q) && $stable(mask_q))
        else $error("Status write changed state");

    refresh_event_a: assert property (
        ppmRefresh |=> !mask_q[cms_pkg::EVT_OFFSET_REFRESH] || irq)
        else $error("Refresh event raised no interrupt");
endmodule // cms_status_regs
`default_nettype wire

// File: sim/cms_monitor_model.sv
// Behavioural crystal and output clock monitors
`timescale 1ns/1ps
`default_nettype none
module cms_monitor_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Bench controls
    input wire logic [1:0] losIn,
    input wire logic [1:0] stabIn,
    input wire logic tickEn,
    input wire logic [7:0] ppmIn,
    input wire logic winReq,
    input wire logic [11:0] trueIn,
    input wire logic [11:0] invIn,
    // Monitor outputs
    output logic [1:0] losDetect,
    output logic [1:0] stabilityFail,
    output logic xtalTick,
    output logic [7:0] ppmMeasure,
    output logic windowDone,
    output logic [11:0] trueOutFail,
    output logic [11:0] invertedOutFail
);
    // Crystal monitors follow their controls one edge later
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            losDetect <= 2'h0;
            stabilityFail <= 2'h0;
            xtalTick <= 1'b0;
            ppmMeasure <= 8'h00;
        end else begin
            losDetect <= losIn;
            stabilityFail <= stabIn;
            xtalTick <= tickEn;
            ppmMeasure <= ppmIn;
        end
    end
    // Verdicts mean something only with the window pulse
    always_ff @(posedge clock) begin
        windowDone <= reset_n & winReq;
        trueOutFail <= winReq ? trueIn : ~trueOutFail;
        invertedOutFail <= winReq ? invIn : ~invertedOutFail;
    end
endmodule // cms_monitor_model
`default_nettype wire

// File: sim/cms_status_regs_bench.sv
// Self-checking bench for the clock monitor status registers
`timescale 1ns/1ps
`default_nettype none
module cms_status_regs_bench;
    logic clock, reset_n, hsel, hwrite, hreadyout, hresp, irq;
    logic [1:0] htrans, losIn, stabIn, losDetect, stabilityFail;
    logic [31:0] haddr, hwdata, hrdata, rd, dis;
    logic tickEn, winReq, xtalTick, windowDone;
    logic [7:0] ppmIn, ppmMeasure;
    logic [11:0] trueIn, invIn, trueOutFail, invertedOutFail;
    int errCount, nCompared, seed;

    cms_status_regs #(.REFRESH_CYCLES(8)) i_cms_status_regs (
        .clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .losDetect(losDetect),
        .stabilityFail(stabilityFail), .xtalTick(xtalTick),
        .ppmMeasure(ppmMeasure), .windowDone(windowDone),
        .trueOutFail(trueOutFail), .invertedOutFail(invertedOutFail),
        .irq(irq));
    cms_monitor_model i_cms_monitor_model (
        .clock(clock), .reset_n(reset_n), .losIn(losIn), .stabIn(stabIn),
        .tickEn(tickEn), .ppmIn(ppmIn), .winReq(winReq), .trueIn(trueIn),
        .invIn(invIn), .losDetect(losDetect), .stabilityFail(stabilityFail),
        .xtalTick(xtalTick), .ppmMeasure(ppmMeasure),
        .windowDone(windowDone), .trueOutFail(trueOutFail),
        .invertedOutFail(invertedOutFail));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    function automatic logic [31:0] exp_loss(input logic [31:0] v);
        return {28'h0, v[3:2] | v[5:4] | v[1:0], v[3:2]};
    endfunction
    function automatic logic [31:0] exp_freq(input logic [31:0] v);
        return {8'h00, v[23:12], v[11:0]};
    endfunction

    task end_sim;
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task ready_edge;
        int k;
        k = 0;
        @(posedge clock);
        while (hreadyout !== 1'b1) begin
            k++;
            if (k > 50) begin
                errCount++;
                end_sim();
            end
            @(posedge clock);
        end
    endtask
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] r);
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsel <= 1'b1;
        ready_edge();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        ready_edge();
        r = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask
    task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, rd);
        chk(nm, rd, e);
    endtask
    task settle;
        repeat (3) @(posedge clock);
    endtask

    initial begin
        #1000000;
        errCount++;
        end_sim();
    end

    initial begin
        seed = 32'h17676119;
        errCount = 0;
        nCompared = 0;
        {reset_n, hsel, hwrite, tickEn, winReq} = 5'h00;
        {haddr, hwdata, htrans} = 66'h0;
        {losIn, stabIn, ppmIn, trueIn, invIn} = 36'h0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rdchk("reset value", 8'(i * 4), 32'h0);
        end
        chk("irq", {31'h0, irq}, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            dis = $random(seed);
            bus(1'b1, 8'h0C, {30'h0, dis[1:0]}, rd);
            losIn <= dis[3:2];
            stabIn <= dis[5:4];
            settle();
            rdchk("loss", 8'h00, exp_loss(dis));
        end
        $display("test crystal done");
        for (int i = 0; i < 8; i++) begin
            dis = (i == 0) ? 32'h00800001 : $random(seed);
            trueIn <= dis[11:0];
            invIn <= dis[23:12];
            winReq <= 1'b1;
            @(posedge clock);
            winReq <= 1'b0;
            if (i == 0) @(posedge clock);
            else settle();
            rdchk("freq", 8'h08, exp_freq(dis));
        end
        bus(1'b1, 8'h00, 32'hFFFFFFFF, rd);
        bus(1'b1, 8'h08, 32'hFFFFFFFF, rd);
        rdchk("freq", 8'h08, exp_freq(dis));
        rdchk("freq", 8'h08, exp_freq(dis));
        rdchk("unmapped", 8'h20, 32'h0);
        $display("test output done");
        bus(1'b1, 8'h0C, 32'h0, rd);
        losIn <= 2'h0;
        stabIn <= 2'h0;
        settle();
        bus(1'b0, 8'h10, 32'h0, rd);
        losIn <= 2'h1;
        settle();
        chk("irq masked", {31'h0, irq}, 32'h0);
        bus(1'b1, 8'h14, 32'h1, rd);
        settle();
        chk("irq", {31'h0, irq}, 32'h1);
        rdchk("mask", 8'h14, 32'h1);
        rdchk("event", 8'h10, 32'h1);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        $display("test interrupt done");
        dis = $random(seed);
        ppmIn <= dis[7:0];
        bus(1'b1, 8'h14, 32'h4, rd);
        tickEn <= 1'b1;
        repeat (7) @(posedge clock);
        tickEn <= 1'b0;
        settle();
        rdchk("offset early", 8'h04, 32'h0);
        tickEn <= 1'b1;
        @(posedge clock);
        tickEn <= 1'b0;
        settle();
        rdchk("offset", 8'h04, {24'h0, dis[7:0]});
        chk("irq refresh", {31'h0, irq}, 32'h1);
        rdchk("event", 8'h10, 32'h4);
        $display("test offset done");
        end_sim();
    end
endmodule // cms_status_regs_bench
`default_nettype wire
